/* File: core/sgp_ports.sv */
// gp port block: i/o-mapped data/control registers and config index/data
//
// Summary of operation
// [RULE1] host writes index then config data
// [RULE2] logical device select picks owned config set
// [RULE3] fifteen pins, each input or output
// [RULE4] port one data then three control addresses
// [RULE5] port two data then three control addresses
// [RULE6] port one bit7 zero forces diskette protect
// [RULE7] port one bit6 zero protects flash rom
// [RULE8] bits five four report cable type
// [RULE9] bits three two give bus fraction
// [RULE10] bits one zero give bus frequency
// [RULE11] port two bit6 reads big cache
// [RULE12] port two bit2 reads small cache
// [RULE13] port two bit3 one means onboard cache
// [RULE14] port two bits one zero serial bus
// [RULE15] port two bits seven-four expansion bus
// [RULE16] read returns pin or written value
`timescale 1ns/1ps
module sgp_ports
    import sgp_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // host i/o cycle
    input  wire logic [15:0] io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             io_sel,
    // port one pins
    input  wire logic [7:0]  port_one_in,
    output logic      [7:0]  port_one_out,
    output logic      [7:0]  port_one_oe_n,
    // port two pins
    input  wire logic [7:0]  port_two_in,
    output logic      [7:0]  port_two_out,
    output logic      [7:0]  port_two_oe_n,
    // pull-up enables towards the pads
    output logic      [7:0]  port_one_pull,
    output logic      [7:0]  port_two_pull,
    // decoded board functions
    output logic             diskette_protect_out,
    output logic             flash_protect_out,
    output logic      [1:0]  bus_fraction_code,
    output logic      [1:0]  bus_freq_code
);
    import sgp_pkg::*;

    // ==========================================
    // decode
    // port select: 0 none, 1 port one, 2 port two, sub-offset in low bits
    function automatic logic [1:0] port_hit(input logic [15:0] a);
        if (a[15:2] == SGP_P1_DATA_ADDR[15:2])
            return 2'd1;
        else if (a[15:2] == SGP_P2_DATA_ADDR[15:2])
            return 2'd2;
        else
            return 2'd0;
    endfunction

    // mixes pin level and latch per direction bit, 1 = output
    function automatic logic [7:0] mix(input logic [7:0] dir,
                                       input logic [7:0] latch,
                                       input logic [7:0] pins);
        return (dir & latch) | (~dir & pins);
    endfunction

    logic [1:0] hit;
    logic [1:0] sub;
    logic       cfg_idx_hit;
    logic       cfg_dat_hit;
    assign hit         = port_hit(io_addr);           // RULE4 RULE5
    assign sub         = io_addr[1:0];
    assign cfg_idx_hit = io_addr == SGP_CFG_INDEX_ADDR;
    assign cfg_dat_hit = io_addr == SGP_CFG_DATA_ADDR;
    assign io_sel      = (hit != 2'd0) | cfg_idx_hit | cfg_dat_hit;

    // ==========================================
    // configuration index and logical device select
    logic [7:0] cfg_index_r;
    logic [7:0] ldn_r;
    logic [7:0] ldn_act_r  [SGP_NUM_LDN];
    logic [7:0] ldn_bhi_r  [SGP_NUM_LDN];
    logic [7:0] ldn_blo_r  [SGP_NUM_LDN];
    logic       ldn_ok;
    logic [3:0] ldn_i;
    assign ldn_ok = ldn_r < 8'(SGP_NUM_LDN);
    assign ldn_i  = ldn_r[3:0];

    // data port only acts on the index written before it
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            cfg_index_r <= 8'h00;
        end else if (io_wr && cfg_idx_hit) begin
            cfg_index_r <= io_wdata;                  // RULE1
        end
    end

    // device select steers which owned register set the data port reaches
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ldn_r <= SGP_LDN_RESET;
        end else if (io_wr && cfg_dat_hit
                     && cfg_index_r == SGP_CFG_LDN_INDEX) begin
            ldn_r <= io_wdata;                        // RULE2
        end
    end

    // per-device activate and base registers; writes to absent devices drop
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < SGP_NUM_LDN; i++) begin
                ldn_act_r[i] <= 8'h00;
                ldn_bhi_r[i] <= 8'h00;
                ldn_blo_r[i] <= 8'h00;
            end
        end else if (io_wr && cfg_dat_hit && ldn_ok) begin
            case (cfg_index_r)                        // RULE2
                SGP_CFG_ACT_INDEX: ldn_act_r[ldn_i] <= io_wdata;
                SGP_CFG_BASE_HI:   ldn_bhi_r[ldn_i] <= io_wdata;
                SGP_CFG_BASE_LO:   ldn_blo_r[ldn_i] <= io_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================
    // port registers
    logic [7:0] p1_out_r, p1_dir_r, p1_ot_r, p1_pu_r;
    logic [7:0] p2_out_r, p2_dir_r, p2_ot_r, p2_pu_r;

    // output latches keep written values even for input bits; pins only
    // follow them once the direction bit turns the driver on
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            p1_out_r <= SGP_P1_OUT_RESET;
            p1_dir_r <= SGP_P1_DIR_RESET;
            p1_ot_r  <= SGP_OTYPE_RESET;
            p1_pu_r  <= SGP_PULL_RESET;
        end else if (io_wr && hit == 2'd1) begin
            case (sub)                                // RULE4
                SGP_OFS_DATA:  p1_out_r <= io_wdata;  // RULE6 RULE7
                SGP_OFS_DIR:   p1_dir_r <= io_wdata;  // RULE3
                SGP_OFS_OTYPE: p1_ot_r  <= io_wdata;
                SGP_OFS_PULL:  p1_pu_r  <= io_wdata;
                default: ;
            endcase
        end
    end

    // port two: bit 3 has no pad, so its direction is held at input
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            p2_out_r <= SGP_P2_OUT_RESET;
            p2_dir_r <= SGP_P2_DIR_RESET;
            p2_ot_r  <= SGP_OTYPE_RESET;
            p2_pu_r  <= SGP_PULL_RESET;
        end else if (io_wr && hit == 2'd2) begin
            case (sub)                                // RULE5
                SGP_OFS_DATA:  p2_out_r <= io_wdata;  // RULE14 RULE15
                SGP_OFS_DIR:   p2_dir_r <= io_wdata & SGP_P2_PIN_MASK; // RULE3
                SGP_OFS_OTYPE: p2_ot_r  <= io_wdata;
                SGP_OFS_PULL:  p2_pu_r  <= io_wdata;
                default: ;
            endcase
        end
    end

    // ==========================================
    // pads: output type 0 = open drain (only drives low), 1 = push-pull
    always_comb begin
        port_one_out  = p1_out_r;
        port_two_out  = p2_out_r;
        // RULE16: input bits never turn on a driver
        port_one_oe_n = ~(p1_dir_r & (p1_ot_r | ~p1_out_r));  // RULE16
        port_two_oe_n = ~(p2_dir_r & (p2_ot_r | ~p2_out_r));  // RULE14 RULE15
        port_one_pull = p1_pu_r;
        port_two_pull = p2_pu_r;
    end

    // board functions: bus codes decoded from the live port values, protect lines from the latch
    logic [7:0] p1_view, p2_view;
    assign p1_view = mix(p1_dir_r, p1_out_r, port_one_in);    // RULE16
    assign p2_view = mix(p2_dir_r, p2_out_r, port_two_in);    // RULE16

    // protect lines are active when the latch reads 0
    always_comb begin
        diskette_protect_out = ~p1_out_r[SGP_P1_DISKETTE_BIT];  // RULE6
        flash_protect_out    = ~p1_out_r[SGP_P1_FLASH_BIT];     // RULE7
    end

    // strap codes registered so data outputs come from flip-flops
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            bus_fraction_code <= SGP_FRAC_2_5;
            bus_freq_code     <= SGP_FREQ_TRI;
        end else begin
            bus_fraction_code <= p1_view[SGP_P1_FRAC_LSB +: 2];  // RULE9
            bus_freq_code     <= p1_view[SGP_P1_FREQ_LSB +: 2];  // RULE10
        end
    end

    // ==========================================
    // read data: cable, cache and strap bits pass straight from the pins while their
    // direction bits select input, so software sees the raw levels; registered for a clean data output
    logic [7:0] rd_nxt;
    logic [7:0] cfg_rd;
    always_comb begin
        cfg_rd = 8'h00;
        case (cfg_index_r)
            SGP_CFG_LDN_INDEX: cfg_rd = ldn_r;
            SGP_CFG_ACT_INDEX: cfg_rd = ldn_ok ? ldn_act_r[ldn_i] : 8'h00;
            SGP_CFG_BASE_HI:   cfg_rd = ldn_ok ? ldn_bhi_r[ldn_i] : 8'h00;
            SGP_CFG_BASE_LO:   cfg_rd = ldn_ok ? ldn_blo_r[ldn_i] : 8'h00;
            default:           cfg_rd = 8'h00;
        endcase
    end

    always_comb begin
        rd_nxt = 8'h00;
        if (cfg_idx_hit)
            rd_nxt = cfg_index_r;
        else if (cfg_dat_hit)
            rd_nxt = cfg_rd;
        else if (hit == 2'd1) begin
            case (sub)
                SGP_OFS_DATA:  rd_nxt = p1_view;      // RULE8 RULE16
                SGP_OFS_DIR:   rd_nxt = p1_dir_r;
                SGP_OFS_OTYPE: rd_nxt = p1_ot_r;
                default:       rd_nxt = p1_pu_r;
            endcase
        end else if (hit == 2'd2) begin
            case (sub)
                SGP_OFS_DATA:  rd_nxt = p2_view;      // RULE11 RULE12 RULE13
                SGP_OFS_DIR:   rd_nxt = p2_dir_r;
                SGP_OFS_OTYPE: rd_nxt = p2_ot_r;
                default:       rd_nxt = p2_pu_r;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            io_rdata <= 8'h00;
        else if (io_rd)
            io_rdata <= rd_nxt;
    end

    // ==========================================
    // checks
    property p_input_bit_reads_pin;
        @(posedge clk_sys) disable iff (!reset_n)
        (io_rd && io_addr == SGP_P1_DATA_ADDR && !p1_dir_r[SGP_P1_PRI_CBL_BIT])
        |=> io_rdata[SGP_P1_PRI_CBL_BIT]
            == $past(port_one_in[SGP_P1_PRI_CBL_BIT]);
    endproperty
    a_input_bit_reads_pin: assert property (p_input_bit_reads_pin) // RULE8
        else $error("cable bit does not reflect pin");

    property p_out_bit_reads_latch;
        @(posedge clk_sys) disable iff (!reset_n)
        (io_rd && io_addr == SGP_P2_DATA_ADDR && p2_dir_r[SGP_P2_SM_DATA])
        |=> io_rdata[SGP_P2_SM_DATA] == $past(p2_out_r[SGP_P2_SM_DATA]);
    endproperty
    a_out_bit_reads_latch: assert property (p_out_bit_reads_latch) // RULE16
        else $error("output bit does not read latch");

    sequence s_idx_ldn;
        io_wr && cfg_idx_hit && io_wdata == SGP_CFG_LDN_INDEX;
    endsequence
    sequence s_dat_wr;
        io_wr && cfg_dat_hit;
    endsequence
    property p_ldn_select;
        @(posedge clk_sys) disable iff (!reset_n)
        // host cycles leave one idle edge between index and data
        s_idx_ldn ##1 !io_wr ##1 s_dat_wr |=> ldn_r == $past(io_wdata);
    endproperty
    a_ldn_select: assert property (p_ldn_select) // RULE1
        else $error("device select not taken after index");

    property p_diskette;
        @(posedge clk_sys) disable iff (!reset_n)
        (io_wr && io_addr == SGP_P1_DATA_ADDR)
        |=> diskette_protect_out == !$past(io_wdata[SGP_P1_DISKETTE_BIT]);
    endproperty
    a_diskette: assert property (p_diskette) // RULE6
        else $error("diskette protect wrong");

    property p_flash;
        @(posedge clk_sys) disable iff (!reset_n)
        (io_wr && io_addr == SGP_P1_DATA_ADDR && !io_wdata[SGP_P1_FLASH_BIT])
        |=> flash_protect_out;
    endproperty
    a_flash: assert property (p_flash) // RULE7
        else $error("flash not protected");

    property p_fraction;
        @(posedge clk_sys) disable iff (!reset_n)
        (p1_dir_r[3:2] == 2'b00) ##1 (p1_dir_r[3:2] == 2'b00)
        |-> bus_fraction_code == $past(port_one_in[3:2]);
    endproperty
    a_fraction: assert property (p_fraction) // RULE9
        else $error("fraction code mismatch");

    property p_freq;
        @(posedge clk_sys) disable iff (!reset_n)
        (p1_dir_r[1:0] == 2'b00) ##1 (p1_dir_r[1:0] == 2'b00)
        |-> bus_freq_code == $past(port_one_in[1:0]);
    endproperty
    a_freq: assert property (p_freq) // RULE10
        else $error("frequency code mismatch");

    property p_input_no_drive;
        @(posedge clk_sys) disable iff (!reset_n)
        !p2_dir_r[SGP_P2_ONBOARD] && port_two_oe_n[SGP_P2_ONBOARD];
    endproperty
    a_input_no_drive: assert property (p_input_no_drive) // RULE13
        else $error("input pin driven");

    property p_small_cache;
        @(posedge clk_sys) disable iff (!reset_n)
        (io_rd && io_addr == SGP_P2_DATA_ADDR
         && !p2_dir_r[SGP_P2_SMALL_CACHE] && !p2_dir_r[SGP_P2_BIG_CACHE])
        |=> io_rdata[6] == $past(port_two_in[6])
            && io_rdata[2] == $past(port_two_in[2]);
    endproperty
    a_small_cache: assert property (p_small_cache) // RULE11 RULE12
        else $error("cache detect bits wrong");
endmodule

/* File: core/sgp_pkg.sv */
// package: register map, field positions and reset values of the gp ports
package sgp_pkg;
    // ==========================================
    // i/o addresses
    localparam logic [15:0] SGP_CFG_INDEX_ADDR = 16'h002E;
    localparam logic [15:0] SGP_CFG_DATA_ADDR  = 16'h002F;
    localparam logic [15:0] SGP_P1_DATA_ADDR   = 16'h0078;
    localparam logic [15:0] SGP_P2_DATA_ADDR   = 16'h007C;
    // offsets after a data register
    localparam logic [1:0]  SGP_OFS_DATA  = 2'h0;
    localparam logic [1:0]  SGP_OFS_DIR   = 2'h1;
    localparam logic [1:0]  SGP_OFS_OTYPE = 2'h2;
    localparam logic [1:0]  SGP_OFS_PULL  = 2'h3;
    // ==========================================
    // configuration space
    localparam logic [7:0]  SGP_CFG_LDN_INDEX = 8'h07;
    localparam logic [7:0]  SGP_LDN_GPIO      = 8'h07;
    localparam logic [7:0]  SGP_LDN_RESET     = 8'h00;
    localparam logic [7:0]  SGP_CFG_ACT_INDEX = 8'h30;
    localparam logic [7:0]  SGP_CFG_BASE_HI   = 8'h60;
    localparam logic [7:0]  SGP_CFG_BASE_LO   = 8'h61;
    localparam int          SGP_NUM_LDN       = 9;
    // ==========================================
    // port one fields
    localparam int SGP_P1_DISKETTE_BIT = 7;
    localparam int SGP_P1_FLASH_BIT    = 6;
    localparam int SGP_P1_PRI_CBL_BIT  = 5;
    localparam int SGP_P1_SEC_CBL_BIT  = 4;
    localparam int SGP_P1_FRAC_LSB     = 2;
    localparam int SGP_P1_FREQ_LSB     = 0;
    // port two fields
    localparam int SGP_P2_XBUS_LSB     = 4;
    localparam int SGP_P2_BIG_CACHE    = 6;
    localparam int SGP_P2_ONBOARD      = 3;
    localparam int SGP_P2_SMALL_CACHE  = 2;
    localparam int SGP_P2_SM_DATA      = 1;
    localparam int SGP_P2_SM_CLOCK     = 0;
    // ==========================================
    // reset values: port one drives protect bits low (protected)
    localparam logic [7:0] SGP_P1_DIR_RESET  = 8'hC0;
    localparam logic [7:0] SGP_P1_OUT_RESET  = 8'h00;
    localparam logic [7:0] SGP_P2_DIR_RESET  = 8'h00;
    localparam logic [7:0] SGP_P2_OUT_RESET  = 8'hFF;
    localparam logic [7:0] SGP_OTYPE_RESET   = 8'h00;
    localparam logic [7:0] SGP_PULL_RESET    = 8'h00;
    // port two pins that exist (15 pins in total with port one's 8)
    localparam logic [7:0] SGP_P2_PIN_MASK   = 8'hF7;
    // fraction and frequency codes
    localparam logic [1:0] SGP_FRAC_2_5 = 2'h0;
    localparam logic [1:0] SGP_FRAC_1_2 = 2'h2;
    localparam logic [1:0] SGP_FRAC_1_3 = 2'h1;
    localparam logic [1:0] SGP_FRAC_2_7 = 2'h3;
    localparam logic [1:0] SGP_FREQ_TRI = 2'h0;
    localparam logic [1:0] SGP_FREQ_66  = 2'h1;
    localparam logic [1:0] SGP_FREQ_50  = 2'h2;
    localparam logic [1:0] SGP_FREQ_60  = 2'h3;
endpackage

/* File: tb/sgp_board_model.sv */
// board model: strap resistors and the serial memory bus on the gp pins
`timescale 1ns/1ps
module sgp_board_model (
    // design pin side
    input  wire logic [7:0] port_one_out,
    input  wire logic [7:0] port_one_oe_n,
    input  wire logic [7:0] port_two_out,
    input  wire logic [7:0] port_two_oe_n,
    // board settings chosen by the bench
    input  wire logic [7:0] strap_one,
    input  wire logic [7:0] strap_two,
    input  wire logic       mem_data_low,
    // pad levels back into the design
    output logic      [7:0] port_one_in,
    output logic      [7:0] port_two_in
);
    // ==========================================
    // pad resolution
    // straps are weak resistors, so a driving pin always wins over them
    always_comb begin
        port_one_in = (port_one_oe_n & strap_one)
                    | (~port_one_oe_n & port_one_out);
        port_two_in = (port_two_oe_n & strap_two)
                    | (~port_two_oe_n & port_two_out);
        // serial bus lines are wired-and with a board pull-up
        port_two_in[1] = (port_two_oe_n[1] | port_two_out[1])
                       & ~mem_data_low;
        port_two_in[0] = port_two_oe_n[0] | port_two_out[0];
    end
endmodule

/* File: tb/test_sgp_ports.sv */
// testbench: host i/o cycles against the gp port block and board model
`timescale 1ns/1ps
module test_sgp_ports;
    import sgp_pkg::*;
    logic        clk_sys      = 1'b0;
    logic        reset_n      = 1'b0;
    logic [15:0] io_addr      = 16'h0000;
    logic        io_wr        = 1'b0;
    logic        io_rd        = 1'b0;
    logic [7:0]  io_wdata     = 8'h00;
    logic [7:0]  strap_one    = 8'h00;
    logic [7:0]  strap_two    = 8'h00;
    logic        mem_data_low = 1'b0;
    logic [7:0]  io_rdata, p1_in, p1_out, p1_oe_n, p2_in, p2_out, p2_oe_n;
    logic [7:0]  p1_pull, p2_pull;
    logic        io_sel, disk_prot, flash_prot;
    logic [1:0]  frac_code, freq_code;
    int          fail_count   = 0;
    int          n_compared   = 0;
    int          cycles       = 0;

    // ==========================================
    // clock, timeout and instances
    always #12.5 clk_sys = ~clk_sys;
    // the whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            report_and_stop();
        end
    end
    sgp_ports sgp_ports_i (.clk_sys(clk_sys), .reset_n(reset_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .io_sel(io_sel),
        .port_one_in(p1_in), .port_one_out(p1_out), .port_one_oe_n(p1_oe_n),
        .port_two_in(p2_in), .port_two_out(p2_out), .port_two_oe_n(p2_oe_n),
        .port_one_pull(p1_pull), .port_two_pull(p2_pull),
        .diskette_protect_out(disk_prot), .flash_protect_out(flash_prot),
        .bus_fraction_code(frac_code), .bus_freq_code(freq_code));
    sgp_board_model sgp_board_model_i (.port_one_out(p1_out),
        .port_one_oe_n(p1_oe_n), .port_two_out(p2_out),
        .port_two_oe_n(p2_oe_n), .strap_one(strap_one),
        .strap_two(strap_two), .mem_data_low(mem_data_low),
        .port_one_in(p1_in), .port_two_in(p2_in));

    // ==========================================
    // host cycle tasks; inputs move 1 ns after the rising edge
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic io_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        io_wr = 1'b0;
    endtask
    task automatic rd_check(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        #1;
        io_addr = a;
        io_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        io_rd = 1'b0;
        check(io_rdata, exp);
    endtask
    // index first, then data, as the host must
    task automatic cfg_write(input logic [7:0] idx, input logic [7:0] val);
        io_write(SGP_CFG_INDEX_ADDR, idx);
        io_write(SGP_CFG_DATA_ADDR, val);
    endtask
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================
    // main sequence
    initial begin
        logic [1:0]  frac_tab [4];
        logic [1:0]  freq_tab [4];
        logic [15:0] bad_tab  [3];
        logic [7:0]  s;
        logic [15:0] a;
        frac_tab = '{SGP_FRAC_2_5, SGP_FRAC_1_2, SGP_FRAC_1_3, SGP_FRAC_2_7};
        freq_tab = '{SGP_FREQ_TRI, SGP_FREQ_66, SGP_FREQ_50, SGP_FREQ_60};
        bad_tab = '{16'h0080, 16'h0077, 16'h0178};
        repeat (16) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        // protect outputs come up driven low, everything else released
        check(p1_oe_n, 8'h3F);
        check(p2_oe_n, 8'hFF);
        check(disk_prot, 1'b1);
        check(flash_prot, 1'b1);
        for (int i = 0; i < 4; i++) begin
            io_write(SGP_P1_DATA_ADDR, {2'(i), 6'h00});
            check(disk_prot, !i[1]);
            check(flash_prot, !i[0]);
        end
        // straps: every cable, fraction and frequency code
        for (int i = 0; i < 4; i++) begin
            s = {2'b00, 2'(i), frac_tab[i], freq_tab[3 - i]};
            strap_one = s;
            repeat (4) @(posedge clk_sys);
            rd_check(SGP_P1_DATA_ADDR, {2'b11, s[5:0]});
            check(frac_code, frac_tab[i]);
            check(freq_code, freq_tab[3 - i]);
        end
        // writes to input bits leave the pads alone
        io_write(SGP_P1_DATA_ADDR, 8'h3F);
        check(p1_oe_n[5:0], 6'h3F);
        check(p1_out, 8'h3F);
        check(io_sel, 1'b1);
        rd_check(SGP_P1_DATA_ADDR, {2'b00, s[5:0]});
        // port two: cache straps with all pins as inputs
        strap_two = 8'h40;
        repeat (4) @(posedge clk_sys);
        rd_check(SGP_P2_DATA_ADDR, 8'h43);
        strap_two = 8'h08;
        repeat (4) @(posedge clk_sys);
        rd_check(SGP_P2_DATA_ADDR, 8'h0B);
        // expansion bus push-pull, serial bus open drain
        io_write(16'h007D, 8'hF3);
        io_write(16'h007E, 8'hF0);
        io_write(SGP_P2_DATA_ADDR, 8'hA0);
        check(p2_out[7:4], 4'hA);
        check(p2_oe_n, 8'h0C);
        rd_check(SGP_P2_DATA_ADDR, 8'hA8);
        io_write(SGP_P2_DATA_ADDR, 8'hA3);
        check(p2_oe_n[1:0], 2'b11);
        io_write(16'h007D, 8'hF0);
        mem_data_low = 1'b1;
        repeat (4) @(posedge clk_sys);
        rd_check(SGP_P2_DATA_ADDR, 8'hA9);
        mem_data_low = 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_check(SGP_P2_DATA_ADDR, 8'hAB);
        // control registers of both ports; port two bit3 is input only
        for (int i = 0; i < 6; i++) begin
            a = 16'h0079 + 16'((i / 3) * 4 + i % 3);
            s = 8'h5A ^ 8'(i);
            io_write(a, s);
            rd_check(a, (i == 3) ? (s & 8'hF7) : s);
        end
        check(p1_pull, 8'h58);
        check(p2_pull, 8'h5F);
        // each logical device keeps its own activate register
        cfg_write(SGP_CFG_LDN_INDEX, SGP_LDN_GPIO);
        cfg_write(SGP_CFG_ACT_INDEX, 8'h01);
        cfg_write(SGP_CFG_LDN_INDEX, 8'h03);
        cfg_write(SGP_CFG_ACT_INDEX, 8'h02);
        cfg_write(SGP_CFG_LDN_INDEX, SGP_LDN_GPIO);
        io_write(SGP_CFG_INDEX_ADDR, SGP_CFG_ACT_INDEX);
        rd_check(SGP_CFG_DATA_ADDR, 8'h01);
        rd_check(SGP_CFG_INDEX_ADDR, SGP_CFG_ACT_INDEX);
        cfg_write(SGP_CFG_LDN_INDEX, 8'h03);
        io_write(SGP_CFG_INDEX_ADDR, SGP_CFG_ACT_INDEX);
        rd_check(SGP_CFG_DATA_ADDR, 8'h02);
        // a select past the last device owns nothing: writes drop, reads 0
        cfg_write(SGP_CFG_LDN_INDEX, 8'h09);
        cfg_write(SGP_CFG_ACT_INDEX, 8'h55);
        rd_check(SGP_CFG_DATA_ADDR, 8'h00);
        // addresses just outside the map
        for (int i = 0; i < 3; i++) begin
            io_write(bad_tab[i], 8'hFF);
            check(io_sel, 1'b0);
            rd_check(bad_tab[i], 8'h00);
        end
        check(p2_pull, 8'h5F);
        report_and_stop();
    end
endmodule
